// ### common/serdes_tuning_pkg.sv
package serdes_tuning_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] SER_SPREAD_ADDR   = 8'h04;
  localparam logic [7:0] SER_EMPHASIS_ADDR = 8'h05;
  localparam logic [7:0] SER_FORCE_ADDR    = 8'h06;
  localparam logic [7:0] DES_SPREAD_ADDR   = 8'h04;
  localparam logic [7:0] DES_EQ_ADDR       = 8'h05;
  localparam logic [7:0] DES_INT_ADDR      = 8'h06;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int EMPHASIS_LSB  = 0;
  localparam int DRIVE_LSB     = 4;
  localparam int EQ_LSB        = 0;
  localparam int SER_SPREAD_LSB = 0;
  localparam int DES_SPREAD_LSB = 0;
  localparam int FORCE_BIT     = 0;
  localparam int INT_LEVEL_BIT = 4;

  // ****************************************************************
  // Reset and power-up values, equalizer code limit and strap settle count
  // ****************************************************************
  localparam logic [3:0] EMPHASIS_RESET     = 4'h0;
  localparam logic [1:0] DRIVE_RESET        = 2'h3;
  localparam logic [3:0] EQ_DEFAULT_HIGH    = 4'h4;
  localparam logic [3:0] EQ_DEFAULT_LOW     = 4'h9;
  localparam logic [3:0] EQ_MAX_CODE        = 4'hB;
  localparam logic [2:0] SER_SPREAD_HIGH    = 3'h1;
  localparam logic [2:0] SER_SPREAD_LOW     = 3'h0;
  localparam logic [1:0] DES_SPREAD_HIGH    = 2'h1;
  localparam logic [1:0] DES_SPREAD_LOW     = 2'h0;
  localparam logic [1:0] STRAP_SETTLE_COUNT = 2'h3;

  typedef enum logic [2:0]
  {
    LINK_UP      = 3'b001,
    LINK_RESTART = 3'b010,
    LINK_RELOCK  = 3'b100
  } link_state_t;

  // Serial spread in tenths of a percent.
  function automatic logic [5:0] serSpreadTenths(input logic [2:0] sel);
    case (sel)
      3'h1:    serSpreadTenths = 6'h05;
      3'h2:    serSpreadTenths = 6'h0F;
      3'h3:    serSpreadTenths = 6'h14;
      3'h5:    serSpreadTenths = 6'h0A;
      3'h6:    serSpreadTenths = 6'h1E;
      3'h7:    serSpreadTenths = 6'h28;
      default: serSpreadTenths = 6'h00;
    endcase
  endfunction

  // Parallel-output spread in tenths of a percent.
  function automatic logic [5:0] desSpreadTenths(input logic [1:0] sel);
    case (sel)
      2'h1:    desSpreadTenths = 6'h14;
      2'h3:    desSpreadTenths = 6'h28;
      default: desSpreadTenths = 6'h00;
    endcase
  endfunction

  // Codes 0101 to 0111 are not emphasis settings.
  function automatic logic emphasisLegal(input logic [3:0] code);
    emphasisLegal = code[3] || (code <= 4'h4);
  endfunction

endpackage

// ### tb/far_end_model.sv
`timescale 1ns/1ps
module far_end_model
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       intReq,
  input  wire logic       pathReq,
  input  wire logic [7:0] lockWait,
  input  wire logic       spreadOn,
  output logic            remoteIntIn,
  output logic            reverseLinkUp,
  output logic            desLocked
);
  logic [7:0] waitCount;
  logic       lastOn;
  // *****
  // Lock follows the serial stream
  // *****
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      waitCount <= 8'h00;
      lastOn    <= 1'b0;
      desLocked <= 1'b1;
    end
    else
    begin
      lastOn <= spreadOn;
      if (spreadOn != lastOn)
      begin
        desLocked <= 1'b0;
        waitCount <= lockWait;
      end
      else if (waitCount != 8'h00)
        waitCount <= waitCount - 8'h01;
      else
        desLocked <= 1'b1;
    end
  end
  // The reverse path is lost while the far end is out of lock.
  assign reverseLinkUp = pathReq && desLocked;
  assign remoteIntIn   = intReq;
endmodule

// ### tb/serdes_link_tuning_and_interrupt_tb.sv
`timescale 1ns/1ps
module serdes_link_tuning_and_interrupt_tb;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic       clockEnable = 1'b1;
  logic       powerDownN = 1'b1;
  logic       eq_default_pin = 1'b0;
  logic       serSpreadDefaultPin = 1'b1;
  logic       desSpreadDefaultPin = 1'b0;
  logic       intReq = 1'b0;
  logic       pathReq = 1'b1;
  logic [7:0] lockWait = 8'h02;
  logic       regWrite = 1'b0;
  logic       regRead = 1'b0;
  logic       regSelectDes = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData;
  logic [7:0] rd;
  logic       remoteIntIn, reverseLinkUp, desLocked, remoteIntOut, linkRestart, linkAvailable;
  logic [3:0] emphasisCode, eqBoost;
  logic [1:0] drive_level_field, desSpreadSel;
  logic [2:0] serSpreadSel;
  logic [5:0] serialSpreadTenths, parallelSpreadTenths;
  int         fail_count = 0;
  int         num_checks = 0;

  serdes_link_tuning_and_interrupt serdes_link_tuning_and_interrupt_inst
  (
    .clock, .reset, .clockEnable, .powerDownN, .eq_default_pin, .serSpreadDefaultPin,
    .desSpreadDefaultPin, .remoteIntIn, .reverseLinkUp, .desLocked, .regWrite, .regRead,
    .regSelectDes, .regAddr, .regWrData, .regRdData, .remoteIntOut, .emphasisCode,
    .drive_level_field, .eqBoost, .serSpreadSel, .desSpreadSel, .serialSpreadTenths,
    .parallelSpreadTenths, .linkRestart, .linkAvailable
  );
  far_end_model far_end_model_inst
  (
    .clock, .reset, .intReq, .pathReq, .lockWait, .remoteIntIn, .reverseLinkUp, .desLocked,
    .spreadOn(serialSpreadTenths != 6'h00)
  );

  initial
  begin
    forever #2.5 clock = ~clock;
  end

  // *****
  // Shared tasks
  // *****
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Read data is sampled just after the edge that takes the strobe.
  task automatic regOp(input logic wr, input logic des, input logic [7:0] a,
                       input logic [7:0] d);
    @(posedge clock);
    regWrite     <= wr;
    regRead      <= !wr;
    regSelectDes <= des;
    regAddr      <= a;
    regWrData    <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    regRead  <= 1'b0;
    #1 rd = regRdData;
  endtask

  task automatic waitSig(input logic sel, input logic val, input int bound);
    int i;
    for (i = 0; i < bound; i++)
    begin
      if ((sel ? remoteIntOut : linkAvailable) === val)
        break;
      idle(1);
    end
    check(8'(sel ? remoteIntOut : linkAvailable), 8'(val));
    if (i == bound)
      report_and_stop();
  endtask

  task automatic relock;
    waitSig(1'b0, 1'b0, 6);
    waitSig(1'b0, 1'b1, 200);
  endtask

  // *****
  // Scenarios
  // *****
  task automatic testStraps;
    check(8'(eqBoost), 8'h09);
    check(8'(serSpreadSel), 8'h01);
    check(8'(desSpreadSel), 8'h00);
    regOp(1'b0, 1'b0, 8'h05, 8'h00);
    check(rd, 8'h30);
    regOp(1'b0, 1'b0, 8'h10, 8'h00);
    check(rd, 8'h00);
    $display("straps test done");
  endtask

  task automatic testEmphasis;
    logic [3:0] expE;
    logic [1:0] expD;
    expE = 4'h0;
    expD = 2'h3;
    for (int c = 0; c < 16; c++)
    begin
      regOp(1'b1, 1'b0, 8'h05, {4'h3, 4'(c)});
      if (c[3] || c <= 4)
        expE = 4'(c);
      check(8'(emphasisCode), 8'(expE));
    end
    for (int d = 3; d >= 0; d--)
    begin
      regOp(1'b1, 1'b0, 8'h05, {2'h0, 2'(d), 4'h0});
      if (d != 0)
        expD = 2'(d);
      check(8'(drive_level_field), 8'(expD));
    end
    $display("emphasis test done");
  endtask

  task automatic testEq;
    logic [3:0] expQ;
    expQ = 4'h9;
    for (int c = 0; c < 16; c++)
    begin
      regOp(1'b1, 1'b1, 8'h05, 8'(c));
      if (c <= 11)
        expQ = 4'(c);
      regOp(1'b0, 1'b1, 8'h05, 8'h00);
      check(rd, 8'(expQ));
    end
    @(posedge clock);
    eq_default_pin <= 1'b1;
    clockEnable    <= 1'b0;
    regOp(1'b1, 1'b1, 8'h05, 8'h00);
    @(posedge clock);
    clockEnable <= 1'b1;
    idle(8);
    check(8'(eqBoost), 8'h0B);
    $display("eq test done");
  endtask

  task automatic testSpread;
    logic [5:0] serT [8] = '{6'h00, 6'h05, 6'h0F, 6'h14, 6'h00, 6'h0A, 6'h1E, 6'h28};
    logic [5:0] desT [4] = '{6'h00, 6'h14, 6'h00, 6'h28};
    logic       wasOn;
    wasOn = 1'b1;
    @(posedge clock);
    lockWait <= 8'h28;
    for (int s = 0; s < 8; s++)
    begin
      // The modelled link runs below the lowest rate limit, so every code is allowed.
      regOp(1'b1, 1'b0, 8'h04, 8'(s));
      idle(1);
      check(8'(serialSpreadTenths), 8'(serT[s]));
      if ((serT[s] != 6'h00) != wasOn)
        relock();
      wasOn = (serT[s] != 6'h00);
    end
    regOp(1'b1, 1'b0, 8'h04, 8'h00);
    relock();
    for (int d = 0; d < 4; d++)
    begin
      regOp(1'b1, 1'b1, 8'h04, 8'(d));
      idle(1);
      check(8'(parallelSpreadTenths), 8'(desT[d]));
    end
    lockWait <= 8'h02;
    $display("spread test done");
  endtask

  task automatic testPowerDown;
    // Parallel spread goes off before serial spread goes on, so both ends never spread.
    regOp(1'b1, 1'b1, 8'h04, 8'h00);
    regOp(1'b1, 1'b0, 8'h04, 8'h05);
    @(posedge clock);
    serSpreadDefaultPin <= 1'b0;
    desSpreadDefaultPin <= 1'b1;
    powerDownN          <= 1'b0;
    idle(4);
    @(posedge clock);
    powerDownN <= 1'b1;
    idle(10);
    check(8'(eqBoost), 8'h04);
    check(8'(serSpreadSel), 8'h00);
    check(8'(desSpreadSel), 8'h01);
    $display("power-down test done");
  endtask

  task automatic testInterrupt;
    waitSig(1'b0, 1'b1, 200);
    @(posedge clock);
    intReq <= 1'b1;
    waitSig(1'b1, 1'b1, 6);
    regOp(1'b0, 1'b1, 8'h06, 8'h00);
    check(rd, 8'h10);
    @(posedge clock);
    pathReq <= 1'b0;
    intReq  <= 1'b0;
    idle(8);
    check(8'(remoteIntOut), 8'h01);
    @(posedge clock);
    pathReq <= 1'b1;
    waitSig(1'b1, 1'b0, 8);
    @(posedge clock);
    pathReq <= 1'b0;
    idle(2);
    @(posedge clock);
    intReq <= 1'b1;
    idle(4);
    @(posedge clock);
    intReq <= 1'b0;
    idle(6);
    check(8'(remoteIntOut), 8'h00);
    @(posedge clock);
    pathReq <= 1'b1;
    waitSig(1'b1, 1'b1, 8);
    waitSig(1'b1, 1'b0, 4);
    regOp(1'b1, 1'b0, 8'h06, 8'h01);
    idle(1);
    check(8'(remoteIntOut), 8'h01);
    regOp(1'b1, 1'b0, 8'h06, 8'h00);
    idle(1);
    check(8'(remoteIntOut), 8'h00);
    $display("interrupt test done");
  endtask

  initial
  begin
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    idle(8);
    testStraps();
    testEmphasis();
    testEq();
    testSpread();
    testPowerDown();
    testInterrupt();
    report_and_stop();
  end
endmodule

// ### tb/serdes_tuning_props.sv
`timescale 1ns/1ps
module serdes_tuning_props
(
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       remoteIntIn,
  input wire logic       reverseLinkUp,
  input wire logic       desLocked,
  input wire logic       remoteIntOut,
  input wire logic [3:0] emphasisCode,
  input wire logic [1:0] drive_level_field,
  input wire logic [3:0] eqBoost,
  input wire logic [2:0] serSpreadSel,
  input wire logic [1:0] desSpreadSel,
  input wire logic [5:0] serialSpreadTenths,
  input wire logic [5:0] parallelSpreadTenths,
  input wire logic       linkRestart,
  input wire logic       linkAvailable
);
  // *****
  // Field and link checks
  // *****
  default clocking @(posedge clock); endclocking
  default disable iff (reset);

  drive_code_a:
    assert property (drive_level_field != 2'h0) else $error("drive code zero");
  emphasis_code_a:
    assert property (emphasisCode[3] || emphasisCode <= 4'h4) else $error("bad emphasis");
  eq_range_a:
    assert property (eqBoost <= 4'hB) else $error("eq code too high");
  int_forward_a:
    assert property ($rose(remoteIntIn) && reverseLinkUp && linkAvailable
      |-> ##[2:6] remoteIntOut) else $error("interrupt not forwarded");
  ser_decode_a:
    assert property ((serSpreadSel == 3'h6)[*2] |-> serialSpreadTenths == 6'h1E)
      else $error("serial decode");
  des_decode_a:
    assert property ((desSpreadSel == 2'h3)[*2] |-> parallelSpreadTenths == 6'h28)
      else $error("parallel decode");
  restart_pulse_a:
    assert property (linkRestart |-> !linkAvailable ##1 !linkRestart)
      else $error("restart pulse");
  restart_cause_a:
    assert property ($changed(serialSpreadTenths == 6'h00) |-> ##[0:3] linkRestart)
      else $error("no restart on spread change");
  relock_hold_a:
    assert property ((!linkAvailable && !desLocked)[*4] |=> !linkAvailable)
      else $error("link up without lock");

  cover property (linkRestart);
  cover property ($fell(remoteIntOut));
  cover property (eqBoost == 4'hB);
endmodule

bind serdes_link_tuning_and_interrupt serdes_tuning_props serdes_tuning_props_inst
(
  .clock, .reset, .remoteIntIn, .reverseLinkUp, .desLocked, .remoteIntOut, .emphasisCode,
  .drive_level_field, .eqBoost, .serSpreadSel, .desSpreadSel, .serialSpreadTenths,
  .parallelSpreadTenths, .linkRestart, .linkAvailable
);

// ### verilog/int_resender.sv
`timescale 1ns/1ps
module int_resender
(
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic clockEnable,
  input  wire logic intLevel,
  input  wire logic pathUp,
  output logic      sentLevel,
  output logic      bounce
);
  logic prevLevel;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      prevLevel <= 1'b0;
    else if (clockEnable)
      prevLevel <= intLevel;
  end

  // A pulse that starts and ends while the path is down would leave the
  // level unchanged; the bounce flag keeps it so both edges still go out.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      bounce <= 1'b0;
    else if (clockEnable)
    begin
      if (!pathUp && (intLevel != prevLevel) && (intLevel == sentLevel))
        bounce <= 1'b1; // R02
      else if (pathUp && (intLevel == sentLevel))
        bounce <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      sentLevel <= 1'b0;
    else if (clockEnable && pathUp && ((intLevel != sentLevel) || bounce))
      sentLevel <= ~sentLevel; // R01 R02
  end

endmodule

// ### verilog/serdes_link_tuning_and_interrupt.sv
`timescale 1ns/1ps
// How it works
// (R01) Serializer interrupt output repeats every edge of the deserializer interrupt input.
// (R02) Edges seen while the reverse path is down are sent once it returns.
// (R03) Deserializer register 0x06 bit D4 shows the interrupt input level.
// (R04) Host force bit also drives the serializer interrupt output.
// (R05) Emphasis field 0x05 D[3:0] takes thirteen codes: none, deemphasis, preemphasis.
// (R06) Drive field D[5:4]: 11 full (default), 10 three-quarter, 01 half.
// (R07) Equalizer field D[3:0] takes codes 0000 to 1011, rising boost.
// (R08) Equalizer powers up at 0100 with default pin high, 1001 when low.
// (R09) Equalizer default pin is read only at power-up or power-down exit.
// (R10) Serial spread select decodes to none, 0.5, 1.5, 2, none, 1, 3, 4 percent.
// (R11) Serial spread presets to 0.5% with its default pin high, else none.
// (R12) Parallel spread presets to 2% with its default pin high, else none.
// (R13) Spread default pins are read only at power-up or power-down exit.
// (R14) Deserializer spread hits parallel outputs; serializer spread hits serial link too.
// (R15) Parallel spread has exactly two nonzero rates, 2% and 4%.
// (R16) Host must not enable spread on both ends at once.
// (R17) Host limits serial spread by link bit rate.
// (R18) Serial spread on/off restarts the link until the deserializer relocks.
// (R19) Parallel spread select: 00 and 10 none, 01 2%, 11 4%.
module serdes_link_tuning_and_interrupt
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       clockEnable,
  input  wire logic       powerDownN,
  input  wire logic       eq_default_pin,
  input  wire logic       serSpreadDefaultPin,
  input  wire logic       desSpreadDefaultPin,
  input  wire logic       remoteIntIn,
  input  wire logic       reverseLinkUp,
  input  wire logic       desLocked,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic       regSelectDes,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  output logic            remoteIntOut,
  output logic      [3:0] emphasisCode,
  output logic      [1:0] drive_level_field,
  output logic      [3:0] eqBoost,
  output logic      [2:0] serSpreadSel,
  output logic      [1:0] desSpreadSel,
  output logic      [5:0] serialSpreadTenths,
  output logic      [5:0] parallelSpreadTenths,
  output logic            linkRestart,
  output logic            linkAvailable
);
  import serdes_tuning_pkg::*;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] pdSync;
  logic [1:0] eqPinSync;
  logic [1:0] serSsSync;
  logic [1:0] desSsSync;
  logic [1:0] intSync;
  logic [1:0] lockSync;
  logic       pdLast;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      pdSync    <= 2'h0;
      eqPinSync <= 2'h0;
      serSsSync <= 2'h0;
      desSsSync <= 2'h0;
      intSync   <= 2'h0;
      lockSync  <= 2'h0;
    end
    else if (clockEnable)
    begin
      pdSync    <= {pdSync[0], powerDownN};
      eqPinSync <= {eqPinSync[0], eq_default_pin};
      serSsSync <= {serSsSync[0], serSpreadDefaultPin};
      desSsSync <= {desSsSync[0], desSpreadDefaultPin};
      intSync   <= {intSync[0], remoteIntIn};
      lockSync  <= {lockSync[0], desLocked};
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      pdLast <= 1'b0;
    else if (clockEnable)
      pdLast <= pdSync[1];
  end

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  // The straps are loaded only once the synchronisers hold real pin
  // levels, so a settle count runs after reset and after power-down exit.
  logic [1:0] settleCount;
  logic       strapsDone;
  logic       loadStraps;
  logic       wakeEdge;

  assign wakeEdge   = pdSync[1] && !pdLast;
  assign loadStraps = clockEnable && !strapsDone && pdSync[1] &&
                      (settleCount == STRAP_SETTLE_COUNT);

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      settleCount <= 2'h0;
    else if (clockEnable)
    begin
      if (wakeEdge || !pdSync[1])
        settleCount <= 2'h0;
      else if (settleCount != STRAP_SETTLE_COUNT)
        settleCount <= settleCount + 2'h1;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      strapsDone <= 1'b0;
    else if (clockEnable)
    begin
      if (wakeEdge)
        strapsDone <= 1'b0; // R09 R13
      else if (loadStraps)
        strapsDone <= 1'b1; // R09 R13
    end
  end

  // ****************************************************************
  // Register writes
  // ****************************************************************
  logic serWrite;
  logic desWrite;
  logic forceBit;

  assign serWrite = clockEnable && regWrite && !regSelectDes;
  assign desWrite = clockEnable && regWrite && regSelectDes;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      emphasisCode      <= EMPHASIS_RESET;
      drive_level_field <= DRIVE_RESET;
    end
    else if (serWrite && (regAddr == SER_EMPHASIS_ADDR))
    begin
      // Reserved emphasis codes are refused so the driver never sees them.
      if (emphasisLegal(regWrData[EMPHASIS_LSB +: 4]))
        emphasisCode <= regWrData[EMPHASIS_LSB +: 4]; // R05
      if (regWrData[DRIVE_LSB +: 2] != 2'h0)
        drive_level_field <= regWrData[DRIVE_LSB +: 2]; // R06
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      eqBoost <= EQ_DEFAULT_LOW;
    else if (loadStraps)
      eqBoost <= eqPinSync[1] ? EQ_DEFAULT_HIGH : EQ_DEFAULT_LOW; // R08
    else if (desWrite && (regAddr == DES_EQ_ADDR) &&
             (regWrData[EQ_LSB +: 4] <= EQ_MAX_CODE))
      eqBoost <= regWrData[EQ_LSB +: 4]; // R07
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      serSpreadSel <= SER_SPREAD_LOW;
    else if (loadStraps)
      serSpreadSel <= serSsSync[1] ? SER_SPREAD_HIGH : SER_SPREAD_LOW; // R11
    else if (serWrite && (regAddr == SER_SPREAD_ADDR))
      serSpreadSel <= regWrData[SER_SPREAD_LSB +: 3];
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      desSpreadSel <= DES_SPREAD_LOW;
    else if (loadStraps)
      desSpreadSel <= desSsSync[1] ? DES_SPREAD_HIGH : DES_SPREAD_LOW; // R12
    else if (desWrite && (regAddr == DES_SPREAD_ADDR))
      desSpreadSel <= regWrData[DES_SPREAD_LSB +: 2];
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      forceBit <= 1'b0;
    else if (serWrite && (regAddr == SER_FORCE_ADDR))
      forceBit <= regWrData[FORCE_BIT];
  end

  // ****************************************************************
  // Spread decode
  // ****************************************************************
  // The serial rate spreads the link and so also the far parallel side;
  // the parallel rate never touches the serial link.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      serialSpreadTenths   <= 6'h00;
      parallelSpreadTenths <= 6'h00;
    end
    else if (clockEnable)
    begin
      serialSpreadTenths   <= serSpreadTenths(serSpreadSel); // R10 R14
      parallelSpreadTenths <= desSpreadTenths(desSpreadSel); // R14 R15 R19
    end
  end

  // ****************************************************************
  // Link restart on spread on/off
  // ****************************************************************
  logic        serSpreadOnLast;
  logic        serSpreadOn;
  logic        lockDropped;
  link_state_t linkState;
  link_state_t next_linkState;

  assign serSpreadOn = serSpreadTenths(serSpreadSel) != 6'h00;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      serSpreadOnLast <= 1'b0;
    else if (clockEnable)
      serSpreadOnLast <= serSpreadOn;
  end

  always_comb
  begin
    next_linkState = linkState;
    case (linkState)
      LINK_UP:
        if (serSpreadOn != serSpreadOnLast)
          next_linkState = LINK_RESTART; // R18
      LINK_RESTART:
        next_linkState = LINK_RELOCK;
      LINK_RELOCK:
        if (serSpreadOn != serSpreadOnLast)
          next_linkState = LINK_RESTART;
        else if (lockSync[1] && lockDropped)
          next_linkState = LINK_UP; // R18
      default:
        next_linkState = LINK_RESTART;
    endcase
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      linkState <= LINK_UP;
    else if (clockEnable)
      linkState <= next_linkState;
  end

  // The lock synchroniser still holds the level from before the restart,
  // so a lock is trusted only after the loss of lock has been seen.
  // A far end that never shows a loss of lock keeps the link down.
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      lockDropped <= 1'b0;
    else if (clockEnable)
    begin
      if (linkState != LINK_RELOCK)
        lockDropped <= 1'b0;
      else if (!lockSync[1])
        lockDropped <= 1'b1; // R18
    end
  end

  assign linkRestart   = linkState == LINK_RESTART;
  assign linkAvailable = linkState == LINK_UP;

  // ****************************************************************
  // Interrupt forwarding
  // ****************************************************************
  logic forwardedLevel;

  int_resender int_resender_inst
  (
    .clock       (clock),
    .reset       (reset),
    .clockEnable (clockEnable),
    .intLevel    (intSync[1]),
    .pathUp      (reverseLinkUp && linkAvailable), // R02
    .sentLevel   (forwardedLevel),
    .bounce      ()
  );

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      remoteIntOut <= 1'b0;
    else if (clockEnable)
      remoteIntOut <= forwardedLevel || forceBit; // R01 R04
  end

  // ****************************************************************
  // Register reads
  // ****************************************************************
  logic [7:0] next_regRdData;

  always_comb
  begin
    next_regRdData = 8'h00;
    if (regSelectDes)
    begin
      case (regAddr)
        DES_SPREAD_ADDR: next_regRdData[DES_SPREAD_LSB +: 2] = desSpreadSel;
        DES_EQ_ADDR:     next_regRdData[EQ_LSB +: 4] = eqBoost;
        DES_INT_ADDR:    next_regRdData[INT_LEVEL_BIT] = intSync[1]; // R03
        default:         next_regRdData = 8'h00;
      endcase
    end
    else
    begin
      case (regAddr)
        SER_SPREAD_ADDR: next_regRdData[SER_SPREAD_LSB +: 3] = serSpreadSel;
        SER_EMPHASIS_ADDR:
        begin
          next_regRdData[EMPHASIS_LSB +: 4] = emphasisCode;
          next_regRdData[DRIVE_LSB +: 2]    = drive_level_field;
        end
        SER_FORCE_ADDR:  next_regRdData[FORCE_BIT] = forceBit;
        default:         next_regRdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      regRdData <= 8'h00;
    else if (clockEnable && regRead)
      regRdData <= next_regRdData;
  end

endmodule
